/* irq_regs_consts.vh */
/*
 * Constants for the interrupt flag and enable register bank: register
 * offsets, implemented-bit masks, reset values and status bit positions.
 * Assumes it is included by bare name from the design files.
 */
`ifndef IRQ_REGS_CONSTS_VH
`define IRQ_REGS_CONSTS_VH

// ****************************************************************
// Register byte offsets (one aligned word each)
// ****************************************************************
`define OFS_PRIMARY_IRQ_CTRL_A 8'h00
`define OFS_PRIMARY_IRQ_CTRL_B 8'h04
`define OFS_PRIMARY_IRQ_CTRL_C 8'h08
`define OFS_PRIMARY_IRQ_CTRL_D 8'h0c
`define OFS_SHARED_VECTOR_GROUP_A 8'h10
`define OFS_SHARED_VECTOR_GROUP_B 8'h14
`define OFS_EVENT_STATUS 8'h18
`define OFS_EVENT_MASK 8'h1c
`define MAP_TOP_BITS 3'h0

// ****************************************************************
// Implemented bits and reset values
// ****************************************************************
`define MASK_PRIMARY_A 8'h7f
`define MASK_PRIMARY_B 8'hff
`define MASK_PRIMARY_C 8'hff
`define MASK_PRIMARY_D 8'h77
`define MASK_GROUP_A 8'hff
`define MASK_GROUP_B 8'h77
`define RST_IRQ_REG 8'h00
`define NUM_BANK_REGS 6

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_GLOBAL_EN 0
`define BIT_PIN0_FLAG_A 4
`define BIT_PIN1_FLAG_A 5
`define BIT_PIN2_FLAG_D 4
`define BIT_PIN3_FLAG_D 5

// ****************************************************************
// Event status bits (sticky, write one to clear)
// ****************************************************************
`define NUM_EVENTS 3
`define EVT_WAKE 0
`define EVT_SERVICE 1
`define EVT_NEW_FLAG 2

// ****************************************************************
// Bus responses
// ****************************************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* axil_slave.v */
/*
 * AXI4-Lite slave front end: accepts write address and data in either
 * order, issues a one-cycle write strobe, answers reads one cycle after
 * the address is taken.
 * Assumes the owner decodes addresses and supplies read data combinationally.
 */
`timescale 1ns/1ns
`include "irq_regs_consts.vh"

module axil_slave #(
    parameter AW = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [AW-1:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [AW-1:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    output wire wr_en,
    output reg [AW-1:0] wr_addr,
    output reg [31:0] wr_data,
    output reg [3:0] wr_strb,
    input wire wr_ok,
    output wire [AW-1:0] rd_addr,
    input wire [31:0] rd_data,
    input wire rd_ok
);

reg aw_have_q;
reg w_have_q;
reg aw_have_d;
reg w_have_d;
reg bvalid_d;

// Both halves held and no response outstanding
assign wr_en = aw_have_q & w_have_q & ~bvalid;
// Address is held by the master while arvalid is high
assign rd_addr = araddr;

// ****************************************************************
// Write channel
// ****************************************************************
// Next holding state, used for the registered readies
always @*
begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    bvalid_d = bvalid;
    if (bvalid && bready)
        bvalid_d = 1'b0;
    if (wr_en)
    begin
        aw_have_d = 1'b0;
        w_have_d = 1'b0;
        bvalid_d = 1'b1;
    end
    if (awvalid && awready)
        aw_have_d = 1'b1;
    if (wvalid && wready)
        w_have_d = 1'b1;
end

// Capture halves; ready drops while a half is held or a response waits
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid <= 1'b0;
        bresp <= `RESP_OKAY;
        awready <= 1'b0;
        wready <= 1'b0;
        wr_addr <= {AW{1'b0}};
        wr_data <= 32'h0;
        wr_strb <= 4'h0;
    end
    else
    begin
        aw_have_q <= aw_have_d;
        w_have_q <= w_have_d;
        bvalid <= bvalid_d;
        awready <= ~aw_have_d & ~bvalid_d;
        wready <= ~w_have_d & ~bvalid_d;
        if (awvalid && awready)
            wr_addr <= awaddr;
        if (wvalid && wready)
        begin
            wr_data <= wdata;
            wr_strb <= wstrb;
        end
        if (wr_en)
            bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
end

// ****************************************************************
// Read channel
// ****************************************************************
// One read at a time; data sampled at the address handshake
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        arready <= 1'b0;
        rvalid <= 1'b0;
        rdata <= 32'h0;
        rresp <= `RESP_OKAY;
    end
    else if (rvalid)
    begin
        if (rready)
        begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end
    else if (arvalid && arready)
    begin
        rvalid <= 1'b1;
        arready <= 1'b0;
        rdata <= rd_ok ? rd_data : 32'h0;
        rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    else
        arready <= 1'b1;
end

endmodule // axil_slave

/* event_status.v */
/*
 * Sticky event status with write-one-to-clear, a mask of the same layout
 * and one registered level interrupt.
 * Assumes event inputs are one-cycle pulses or levels in the aclk domain.
 */
`timescale 1ns/1ns
`include "irq_regs_consts.vh"

module event_status #(
    parameter N = 3
) (
    input wire aclk,
    input wire aresetn,
    input wire [N-1:0] evt,
    input wire stat_wr,
    input wire [N-1:0] stat_wdata,
    input wire mask_wr,
    input wire [N-1:0] mask_wdata,
    output reg [N-1:0] status_q,
    output reg [N-1:0] mask_q,
    output reg irq_q
);

wire [N-1:0] status_d;

// A new event beats a clear in the same cycle
assign status_d = (status_q & ~(stat_wr ? stat_wdata : {N{1'b0}})) | evt;

// Status, mask and the gated interrupt level
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        status_q <= {N{1'b0}};
        mask_q <= {N{1'b0}};
        irq_q <= 1'b0;
    end
    else
    begin
        status_q <= status_d;
        if (mask_wr)
            mask_q <= mask_wdata;
        irq_q <= |(status_d & (mask_wr ? mask_wdata : mask_q));
    end
end

endmodule // event_status

/* irq_flag_regs.v */
/*
 * Interrupt request flag and enable register bank: six 8-bit registers
 * holding source request flags, per-source enables and the global enable,
 * with hardware set, service clears, group merging, wake and vector request.
 * Assumes source events, service acknowledges and the low-power level are
 * synchronous one-clock signals from the core; software reaches the bank
 * over AXI4-Lite.
 */
`timescale 1ns/1ns
`include "irq_regs_consts.vh"

module irq_flag_regs #(
    parameter AW = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [3:0] pin_evt,
    input wire [1:0] cmp_evt,
    input wire adc_evt,
    input wire [1:0] tick_evt,
    input wire [2:0] grp_ext_evt,
    input wire [3:0] tm0_evt,
    input wire [2:0] enh_evt,
    input wire svc_ack,
    input wire [3:0] svc_pin,
    input wire low_power,
    output reg int_req,
    output wire global_irq_enable,
    output reg wake,
    output wire irq
);

// ****************************************************************
// Declarations
// ****************************************************************
wire wr_en;
wire [AW-1:0] wr_addr;
wire [31:0] wr_data;
wire [3:0] wr_strb;
wire [AW-1:0] rd_addr;
reg [31:0] rd_data;
wire wr_ok;
wire rd_ok;
wire [2:0] wr_idx;
wire [2:0] rd_idx;
wire wr_lane0;

wire [47:0] bank_q;
wire [47:0] bank_d;
wire [47:0] set_all;
wire [47:0] clr_all;
wire [47:0] mask_all;
wire [47:0] flag_pos;

wire [7:0] reg_a;
wire [7:0] reg_b;
wire [7:0] reg_c;
wire [7:0] reg_d;
wire [7:0] grp_a;
wire [7:0] grp_b;

wire group0_set;
wire group1_set;
wire [3:0] pend_a;
wire [3:0] pend_b;
wire [3:0] pend_c;
wire [3:0] pend_d;
wire any_primary;

reg [47:0] flags_prev_q;
wire new_flag;
wire [`NUM_EVENTS-1:0] evt_vec;
wire [`NUM_EVENTS-1:0] status_q;
wire [`NUM_EVENTS-1:0] mask_q;

// ****************************************************************
// Bus front end
// ****************************************************************
// Handshakes and responses live in the slave; decoding stays here
axil_slave #(
    .AW(AW)
) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
);

// Eight words mapped; anything above answers with an error
assign wr_ok = (wr_addr[AW-1:5] == `MAP_TOP_BITS);
assign rd_ok = (rd_addr[AW-1:5] == `MAP_TOP_BITS);
assign wr_idx = wr_addr[4:2];
assign rd_idx = rd_addr[4:2];
// Registers are 8 bits wide, so only byte lane 0 carries a write
assign wr_lane0 = wr_en & wr_ok & wr_strb[0];

// ****************************************************************
// Register views
// ****************************************************************
// Named slices of the flat bank
assign reg_a = bank_q[7:0];
assign reg_b = bank_q[15:8];
assign reg_c = bank_q[23:16];
assign reg_d = bank_q[31:24];
assign grp_a = bank_q[39:32];
assign grp_b = bank_q[47:40];
assign global_irq_enable = reg_a[`BIT_GLOBAL_EN];

// ****************************************************************
// Hardware set and clear vectors
// ****************************************************************
// Group flags in B are set by enabled sub-source flags, so sub-sources share a vector
assign group0_set = |(grp_a[7:4] & grp_a[3:0]);
assign group1_set = |(grp_b[6:4] & grp_b[2:0]);

// Source events land on their flag positions only
assign set_all[7:0] = {1'b0, cmp_evt[0], pin_evt[1], pin_evt[0], 4'h0};
assign set_all[15:8] = {adc_evt, group1_set, group0_set, cmp_evt[1], 4'h0};
assign set_all[23:16] = {grp_ext_evt[1], tick_evt[1], tick_evt[0], grp_ext_evt[0], 4'h0};
assign set_all[31:24] = {1'b0, grp_ext_evt[2], pin_evt[3], pin_evt[2], 4'h0};
assign set_all[39:32] = {tm0_evt, 4'h0};
assign set_all[47:40] = {1'b0, enh_evt, 4'h0};

// Service clears the global enable, and pin service its own flag too
assign clr_all[7:0] = {2'h0, svc_pin[1], svc_pin[0], 3'h0, svc_ack | (|svc_pin)};
assign clr_all[23:8] = 16'h0;
assign clr_all[31:24] = {2'h0, svc_pin[3], svc_pin[2], 4'h0};
assign clr_all[47:32] = 16'h0;

// Unimplemented positions are never stored
assign mask_all = {`MASK_GROUP_B, `MASK_GROUP_A, `MASK_PRIMARY_D,
                   `MASK_PRIMARY_C, `MASK_PRIMARY_B, `MASK_PRIMARY_A};

// Flag positions, for edge detection of new requests
assign flag_pos = {8'h70, 8'hf0, 8'h70, 8'hf0, 8'hf0, 8'h70};

// ****************************************************************
// Register bank
// ****************************************************************
// Per register: software write, then hardware clear, then hardware set.
// Set comes last so an event in the clearing cycle is never lost.
genvar gi;
generate
    for (gi = 0; gi < `NUM_BANK_REGS; gi = gi + 1)
    begin : g_bank
        wire sel;
        wire [7:0] base;
        reg [7:0] slot_q;
        // One flop per register, so each slice has a single driver
        assign bank_q[gi*8 +: 8] = slot_q;
        assign sel = wr_lane0 & (wr_idx == gi);
        assign base = sel ? wr_data[7:0] : bank_q[gi*8 +: 8];
        assign bank_d[gi*8 +: 8] = ((base & ~clr_all[gi*8 +: 8]) | set_all[gi*8 +: 8])
                                   & mask_all[gi*8 +: 8];

        always @(posedge aclk)
        begin
            if (!aresetn)
                slot_q <= `RST_IRQ_REG;
            else
                slot_q <= bank_d[gi*8 +: 8];
        end
    end
endgenerate

// ****************************************************************
// Vector request
// ****************************************************************
// Primary enables gate only the request, never the stored flag; group enables gate the merged flag in B
assign pend_a = {1'b0, reg_a[6:4] & reg_a[3:1]};
assign pend_b = reg_b[7:4] & reg_b[3:0];
assign pend_c = reg_c[7:4] & reg_c[3:0];
assign pend_d = {1'b0, reg_d[6:4] & reg_d[2:0]};
assign any_primary = |{pend_a, pend_b, pend_c, pend_d};

// Request to the core needs a source enable and the global enable
always @(posedge aclk)
begin
    if (!aresetn)
        int_req <= 1'b0;
    else
        int_req <= any_primary & reg_a[`BIT_GLOBAL_EN] & ~svc_ack & ~(|svc_pin);
end

// ****************************************************************
// Wake and event detection
// ****************************************************************
// A flag already set before sleep does not wake; only a fresh rise does
assign new_flag = |(bank_q & flag_pos & ~flags_prev_q);

// Previous flags and the registered wake level
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        flags_prev_q <= 48'h0;
        wake <= 1'b0;
    end
    else
    begin
        flags_prev_q <= bank_q & flag_pos;
        wake <= low_power & new_flag;
    end
end

// ****************************************************************
// Event status and interrupt
// ****************************************************************
// Events collected for software in the sticky status register
assign evt_vec[`EVT_WAKE] = low_power & new_flag;
assign evt_vec[`EVT_SERVICE] = svc_ack | (|svc_pin);
assign evt_vec[`EVT_NEW_FLAG] = new_flag;

event_status #(
    .N(`NUM_EVENTS)
) u_status (
    .aclk(aclk),
    .aresetn(aresetn),
    .evt(evt_vec),
    .stat_wr(wr_lane0 & (wr_idx == `OFS_EVENT_STATUS >> 2)),
    .stat_wdata(wr_data[`NUM_EVENTS-1:0]),
    .mask_wr(wr_lane0 & (wr_idx == `OFS_EVENT_MASK >> 2)),
    .mask_wdata(wr_data[`NUM_EVENTS-1:0]),
    .status_q(status_q),
    .mask_q(mask_q),
    .irq_q(irq)
);

// ****************************************************************
// Read mux
// ****************************************************************
// Upper bits of every word read as zero
always @*
begin
    rd_data = 32'h0;
    case (rd_idx)
        3'h0: rd_data[7:0] = reg_a;
        3'h1: rd_data[7:0] = reg_b;
        3'h2: rd_data[7:0] = reg_c;
        3'h3: rd_data[7:0] = reg_d;
        3'h4: rd_data[7:0] = grp_a;
        3'h5: rd_data[7:0] = grp_b;
        3'h6: rd_data[`NUM_EVENTS-1:0] = status_q;
        3'h7: rd_data[`NUM_EVENTS-1:0] = mask_q;
        default: rd_data = 32'h0;
    endcase
end

endmodule // irq_flag_regs

/* cpu_service_model.sv */
/*
 * Behavioural core taking interrupts: one service pulse per raised request,
 * prompt or after a wait. Assumes int_req is a level in the aclk domain.
 */
`timescale 1ns/1ns

module cpu_service_model #(
    parameter SLOW_WAIT = 5
) (
    input wire aclk,
    input wire aresetn,
    input wire en,
    input wire slow,
    input wire int_req,
    output reg svc_ack
);
int cnt;
// **********
// Vector fetch
// **********
// Guard on svc_ack: no second pulse while the global clear lands
always @(posedge aclk)
begin
    svc_ack <= 1'b0;
    if (!aresetn || !en || !int_req || svc_ack)
        cnt <= 0;
    else if (cnt >= (slow ? SLOW_WAIT : 0))
    begin
        svc_ack <= 1'b1;
        cnt <= 0;
    end
    else
        cnt <= cnt + 1;
end
endmodule // cpu_service_model

/* irq_flag_regs_checker.sv */
/*
 * Checker for the interrupt flag bank, bound to its top module.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ns

module irq_flag_regs_checker #(
    parameter AW = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire svc_ack,
    input wire [3:0] svc_pin,
    input wire low_power,
    input wire int_req,
    input wire global_irq_enable,
    input wire wake
);
reg [AW-1:0] ar_q;
// Address of the read in flight
always @(posedge aclk)
begin
    if (s_axi_arvalid && s_axi_arready)
        ar_q <= s_axi_araddr;
end
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
// **********
// Properties
// **********
property p_svc_gie; svc_ack |=> !global_irq_enable; endproperty
a_svc_gie: assert property (p_svc_gie) else $error("global enable kept after service");
property p_pin_gie; |svc_pin |=> !global_irq_enable; endproperty
a_pin_gie: assert property (p_pin_gie) else $error("global enable kept after pin service");
property p_svc_req; svc_ack |=> !int_req; endproperty
a_svc_req: assert property (p_svc_req) else $error("request held through service");
property p_gie_req; !global_irq_enable [*2] |-> !int_req; endproperty
a_gie_req: assert property (p_gie_req) else $error("request without global enable");
property p_wake_idle; !low_power [*3] |-> !wake; endproperty
a_wake_idle: assert property (p_wake_idle) else $error("wake while running");
property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
a_r_upper: assert property (p_r_upper) else $error("upper read bits set");
// Bit 7 of A, bits 7 and 3 of D and group B are holes
property p_r_unimp;
    s_axi_rvalid |-> !(ar_q == 8'h00 && s_axi_rdata[7])
        && !((ar_q == 8'h0c || ar_q == 8'h14) && (s_axi_rdata[7] || s_axi_rdata[3]));
endproperty
a_r_unimp: assert property (p_r_unimp) else $error("unimplemented bit read as one");
property p_r_gie; s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00
    |=> s_axi_rdata[0] == $past(global_irq_enable); endproperty
a_r_gie: assert property (p_r_gie) else $error("bit 0 differs from global enable");
endmodule // irq_flag_regs_checker

bind irq_flag_regs irq_flag_regs_checker #(.AW(AW)) u_chk (.*);

/* tb.sv */
/*
 * Bench for the interrupt flag bank: register model, events, service.
 * Assumes design, partner and checker files are compiled first.
 */
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module tb;
logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
logic low_power, svc_on, slow;
logic [7:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata;
logic [3:0] s_axi_wstrb, svc_pin;
logic [18:0] ev;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
wire svc_ack, int_req, global_irq_enable, wake, irq;
// One vector feeds every source so a table can address them
wire [3:0] pin_evt = ev[3:0];
wire [1:0] cmp_evt = ev[5:4];
wire adc_evt = ev[6];
wire [1:0] tick_evt = ev[8:7];
wire [2:0] grp_ext_evt = ev[11:9];
wire [3:0] tm0_evt = ev[15:12];
wire [2:0] enh_evt = ev[18:16];
int errors, comparisons, cyc, wakes, svcs;
int em[6];
// Implemented bits, and register*8+bit set by each source
int mk[6] = '{8'h7f, 8'hff, 8'hff, 8'h77, 8'hff, 8'h77};
int loc[19] = '{4, 5, 28, 29, 6, 12, 15, 21, 22, 20, 23, 30, 36, 37, 38, 39, 44, 45, 46};

irq_flag_regs dut (.*);
cpu_service_model core (.aclk(aclk), .aresetn(aresetn), .en(svc_on), .slow(slow), .int_req(int_req),
    .svc_ack(svc_ack));

initial
begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
end

// **********
// Bus master tasks
// **********
task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    bit done;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    // Local flag: bready itself only updates after this time step
    while (!done && n < 50)
    begin
        @(posedge aclk);
        n++;
        if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid)
        begin
            s_axi_bready <= 1'b0;
            `CHK(s_axi_bresp, er)
            done = 1'b1;
        end
    end
    `CHK(done, 1'b1)
endtask

// Late rready on purpose, so the answer must stand
task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n, dly;
    bit done;
    n = 0;
    done = 1'b0;
    dly = $urandom % 3;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!done && n < 50)
    begin
        @(posedge aclk);
        n++;
        if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rready <= 1'b0;
            `CHK(s_axi_rdata, e)
            `CHK(s_axi_rresp, er)
            done = 1'b1;
        end
        else if (n > dly)
            s_axi_rready <= 1'b1;
    end
    `CHK(done, 1'b1)
endtask

task automatic pulse(input int i);
    @(posedge aclk);
    ev[i] <= 1'b1;
    @(posedge aclk);
    ev[i] <= 1'b0;
    repeat (2) @(posedge aclk);
endtask

task automatic check_all();
    for (int j = 0; j < 6; j++)
        rd(8'(j * 4), 32'(em[j]), 2'h0);
endtask

// Groups first, so merged flags in B do not come back
task automatic clear_all();
    for (int j = 0; j < 6; j++)
    begin
        wr(8'((j + 4) % 6 * 4), 32'h0, 4'hf, 2'h0);
        em[(j + 4) % 6] = 0;
    end
endtask

task automatic close_out();
    $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask

// Cycle ceiling and event counters
always @(posedge aclk)
begin
    cyc++;
    wakes += (wake === 1'b1);
    svcs += (svc_ack === 1'b1);
    if (cyc == 20000)
    begin
        errors++;
        close_out();
    end
end

// **********
// Scenarios
// **********
initial
begin
    int v;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {low_power, svc_on, slow, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, svc_pin, ev} = '0;
    {errors, comparisons, cyc, wakes, svcs} = '0;
    em = '{default: 0};
    void'($urandom(32'hd124));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    check_all();
    rd(8'h18, 32'h0, 2'h0);
    rd(8'h20, 32'h0, 2'h2);
    wr(8'h20, 32'hff, 4'hf, 2'h2);
    $display("test reset: done");
    // Random words; only implemented bits stick, groups merge into B
    for (int j = 0; j < 6; j++)
    begin
        v = $urandom;
        wr(8'(j * 4), v, 4'hf, 2'h0);
        em[j] = v & mk[j];
    end
    if ((em[4] >> 4) & em[4] & 8'h0f)
        em[1] |= 8'h20;
    if ((em[5] >> 4) & em[5] & 8'h07)
        em[1] |= 8'h40;
    wr(8'h08, 32'hff, 4'he, 2'h0);
    check_all();
    clear_all();
    $display("test read-write: done");
    // Every source while asleep: one flag and one wake each
    low_power <= 1'b1;
    wr(8'h18, 32'h7, 4'hf, 2'h0);
    wakes = 0;
    for (int j = 0; j < 19; j++)
    begin
        pulse(j);
        em[loc[j] / 8] |= 1 << (loc[j] % 8);
    end
    check_all();
    `CHK(wakes, 19)
    low_power <= 1'b0;
    rd(8'h18, 32'h5, 2'h0);
    // A mask bit of one lets its status bit through
    `CHK(irq, 1'b0)
    wr(8'h1c, 32'h5, 4'hf, 2'h0);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b1)
    wr(8'h18, 32'h5, 4'hf, 2'h0);
    wr(8'h1c, 32'h0, 4'hf, 2'h0);
    rd(8'h18, 32'h0, 2'h0);
    `CHK(irq, 1'b0)
    clear_all();
    $display("test events: done");
    // Service, prompt then slow
    svc_on <= 1'b1;
    for (int s = 0; s < 2; s++)
    begin
        slow <= s[0];
        svcs = 0;
        wr(8'h00, 32'h71, 4'hf, 2'h0);
        repeat (8) @(posedge aclk);
        `CHK(svcs, 0)
        `CHK(int_req, 1'b0)
        wr(8'h00, 32'h03, 4'hf, 2'h0);
        wr(8'h18, 32'h7, 4'hf, 2'h0);
        pulse(0);
        for (int n = 0; n < 20 && svcs == 0; n++)
            @(posedge aclk);
        `CHK(svcs, 1)
        pulse(4);
        svc_pin <= 4'h1;
        @(posedge aclk);
        svc_pin <= 4'h0;
        rd(8'h00, 32'h42, 2'h0);
        rd(8'h18, 32'h6, 2'h0);
        wr(8'h00, 32'h0, 4'hf, 2'h0);
        $display("test service %0d: done", s);
    end
    close_out();
end
endmodule // tb
